/* File: bench/stc_ext_src.sv */
// partner model: external count source on one of the two crystal pins
`timescale 1ns/1ps
module stc_ext_src (
    input wire logic clk_i,
    input wire logic sel_i,
    output logic osc_input_pin_o,
    output logic osc_output_pin_o
);
    logic lvl = 1'b0;
    // the unselected pin and the idle line sit low, so no stray edge is seen
    assign osc_input_pin_o = sel_i & lvl;
    assign osc_output_pin_o = ~sel_i & lvl;
    // three cycles high and low: above 2 Tosc plus synchroniser margin
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk_i);
            lvl <= 1'b1;
            repeat (3) @(posedge clk_i);
            lvl <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask
endmodule // stc_ext_src

/* File: bench/tb.sv */
// testbench: self-checking run of the 16-bit timer/counter
`timescale 1ns/1ps
module tb;
    import stc_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, sleep_i = 1'b0;
    logic cmp_reset_i = 1'b0, sel = 1'b0;
    logic [7:0] addr_i = 8'h00, wr_data_i = 8'h00, rd_data_o, d;
    logic [1:0] dir = 2'h3;
    logic s_in, s_out, pin_in, pin_out, ii, io, ie, oe, run, irq, tbv;
    logic [15:0] count_o, hold;
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    // a driven pin shows the design's level, otherwise the source's
    assign pin_in = ie ? ii : s_in;
    assign pin_out = oe ? io : s_out;
    stc_timer dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .sleep_i(sleep_i),
        .cmp_reset_i(cmp_reset_i), .port_direction_i(dir), .port_out_i(2'h2),
        .osc_input_pin_i(pin_in), .osc_output_pin_i(pin_out), .osc_input_pin_o(ii),
        .osc_input_pin_oe_o(ie), .osc_output_pin_o(io), .osc_output_pin_oe_o(oe),
        .osc_run_o(run), .irq_o(irq), .time_base_valid_o(tbv), .count_o(count_o));
    stc_ext_src src (.clk_i(clk_i), .sel_i(sel), .osc_input_pin_o(s_in),
        .osc_output_pin_o(s_out));
    initial forever #25 clk_i = ~clk_i;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wr_data_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rd_data_o;
    endtask
    task automatic setcnt(input logic [15:0] v);
        wr(STC_OFS_CNT_LO, v[7:0]);
        wr(STC_OFS_CNT_HI, v[15:8]);
    endtask
    task automatic t_regs();
        rd(STC_OFS_CTRL, d);
        chk("ctrl_rst", 16'(d), 16'h0000);
        wr(STC_OFS_CTRL, 8'hFE);
        dir <= 2'h0;
        rd(STC_OFS_CTRL, d);
        chk("ctrl_rw", 16'(d), 16'h003E);
        chk("osc_run", 16'({run, ie, oe}), 16'h0004);
        wr(STC_OFS_CTRL, 8'h00);
        #1 chk("osc_off", 16'({run, ie, oe}), 16'h0003);
        chk("pin_drv", 16'({ii, io}), 16'h0002);
        @(posedge clk_i);
        dir <= 2'h3;
        rd(8'h55, d);
        chk("unmapped", 16'(d), 16'h0000);
        $display("test regs done");
    endtask
    task automatic t_wrap();
        setcnt(16'hFFFF);
        wr(STC_OFS_IRQEN, 8'h01);
        wr(STC_OFS_CTRL, 8'h01);
        repeat (40) begin
            if (count_o === 16'h0000) break;
            @(posedge clk_i);
            #1;
        end
        chk("wrap", count_o, 16'h0000);
        chk("irq_on", 16'(irq), 16'h0001);
        rd(STC_OFS_FLAG, d);
        chk("flag", 16'(d), 16'h0001);
        wr(STC_OFS_IRQEN, 8'h00);
        #1 chk("irq_mask", 16'(irq), 16'h0000);
        wr(STC_OFS_FLAG, 8'h00);
        $display("test wrap done");
    endtask
    task automatic t_presc();
        for (int r = 0; r < 4; r++) begin
            wr(STC_OFS_CTRL, {2'b00, 2'(r), 4'h1});
            setcnt(16'h0000);
            settle((24 << r) - 1);
            // instruction phase is free running, so one step of slack
            #1 chk("presc", 16'(count_o == 16'h0006 || count_o == 16'h0005), 16'h0001);
        end
        $display("test prescale done");
    endtask
    task automatic t_ext();
        wr(STC_OFS_CTRL, 8'h07);
        setcnt(16'h0000);
        sleep_i <= 1'b1;
        src.pulses(5);
        settle(8);
        chk("async_sleep", count_o, 16'h0005);
        chk("tb_async", 16'(tbv), 16'h0000);
        wr(STC_OFS_CTRL, 8'h03);
        setcnt(16'h0000);
        src.pulses(4);
        settle(8);
        chk("sync_sleep", count_o, 16'h0000);
        chk("tb_sync", 16'(tbv), 16'h0001);
        sleep_i <= 1'b0;
        // nine events since the last clear leave the prescaler off zero
        src.pulses(5);
        settle(8);
        chk("sync_wake", count_o, 16'h0005);
        sel <= 1'b1;
        wr(STC_OFS_CTRL, 8'h2F);
        setcnt(16'h0000);
        src.pulses(7);
        settle(8);
        chk("osc_pin", count_o, 16'h0001);
        $display("test external done");
    endtask
    task automatic t_cmp();
        wr(STC_OFS_CTRL, 8'h31);
        setcnt(16'h1234);
        @(posedge clk_i);
        cmp_reset_i <= 1'b1;
        @(posedge clk_i);
        cmp_reset_i <= 1'b0;
        #1 chk("cmp", 16'(count_o <= 16'h0001), 16'h0001);
        @(posedge clk_i);
        addr_i <= STC_OFS_CNT_LO;
        wr_data_i <= 8'h55;
        wr_i <= 1'b1;
        cmp_reset_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        cmp_reset_i <= 1'b0;
        #1 chk("cmp_wr", 16'(count_o[7:0]), 16'h0055);
        wr(STC_OFS_CTRL, 8'h30);
        #1 hold = count_o;
        settle(100);
        chk("stop", count_o, hold);
        rst_i <= 1'b1;
        settle(2);
        rst_i <= 1'b0;
        rd(STC_OFS_CTRL, d);
        chk("ctrl_por", 16'(d), 16'h0000);
        chk("cnt_kept", count_o, hold);
        $display("test compare and reset done");
    endtask
    initial begin
        settle(2);
        // count has no reset value: load both bytes on the first edges out of reset
        rst_i <= 1'b0;
        addr_i <= STC_OFS_CNT_LO;
        wr_i <= 1'b1;
        @(posedge clk_i);
        addr_i <= STC_OFS_CNT_HI;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1 chk("cnt_load", count_o, 16'h0000);
        t_regs();
        t_wrap();
        t_presc();
        t_ext();
        t_cmp();
        wrap_up();
    end
endmodule // tb

/* File: verilog/stc_pkg.sv */
// package: register map, field positions and timing constants of the 16-bit timer/counter
package stc_pkg;
    localparam int STC_ADDR_W = 8;
    localparam logic [7:0] STC_OFS_FLAG = 8'h0C;
    localparam logic [7:0] STC_OFS_CNT_LO = 8'h0E;
    localparam logic [7:0] STC_OFS_CNT_HI = 8'h0F;
    localparam logic [7:0] STC_OFS_CTRL = 8'h10;
    localparam logic [7:0] STC_OFS_IRQEN = 8'h8C;
    localparam int STC_BIT_RUN = 0;
    localparam int STC_BIT_SRC = 1;
    localparam int STC_BIT_SYNC_DIS = 2;
    localparam int STC_BIT_OSC_EN = 3;
    localparam int STC_BIT_PS_LO = 4;
    localparam int STC_BIT_PS_HI = 5;
    localparam int STC_BIT_OVF_FLAG = 0;
    localparam int STC_BIT_OVF_EN = 0;
    localparam logic [5:0] STC_CTRL_RESET = 6'h00;
    localparam logic [5:0] STC_CTRL_MASK = 6'h3F;
    localparam logic [15:0] STC_COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] STC_COUNT_ONE = 16'h0001;
    localparam logic [1:0] STC_OSC_PER_INSN = 2'h3;
    localparam int STC_SYNC_STAGES = 2;
    localparam int STC_PRESC_W = 3;
endpackage

/* File: verilog/stc_presc_if.sv */
// interface: event, ratio and clear toward the prescaler, tick back
`timescale 1ns/1ps
interface stc_presc_if;
    logic event_in;
    logic [1:0] ratio;
    logic clear;
    logic tick;
    modport ctl (output event_in, output ratio, output clear, input tick);
    modport presc (input event_in, input ratio, input clear, output tick);
endinterface

/* File: verilog/stc_prescaler.sv */
// module: 1:1 to 1:8 input prescaler of the timer/counter
`timescale 1ns/1ps
module stc_prescaler
    import stc_pkg::*;
#(
    parameter int WIDTH = STC_PRESC_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    stc_presc_if.presc pif
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } stc_presc_state_type;

    stc_presc_state_type state;
    stc_presc_state_type next_state;
    logic full;

    if (WIDTH != STC_PRESC_W) begin : g_width_check
        $error("prescaler width must be 3 for ratios up to 1:8");
    end

    // a synchronous counter: the tick passes the event on which the selected low bits are all ones, once every 2**ratio events,
    // so the output is a single-cycle pulse gated by the event and needs no resync of its own
    always_comb begin
        case (pif.ratio)
            2'b00: full = 1'b1;
            2'b01: full = state.cnt[0];
            2'b10: full = &state.cnt[1:0];
            2'b11: full = &state.cnt[2:0];
            default: full = 1'b1;
        endcase
    end

    assign pif.tick = pif.event_in & full & ~pif.clear;

    always_comb begin
        next_state = state;
        if (pif.clear) begin
            next_state.cnt = '0;
        end else if (pif.event_in) begin
            next_state.cnt = state.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    AST_PRESC_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        pif.clear |=> (state.cnt == '0))
        else $error("prescaler not cleared by count write");
endmodule // stc_prescaler

/* File: verilog/stc_timer.sv */
// top: 16-bit timer/counter with prescaler, optional sync, overflow flag and crystal pins
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module stc_timer
    import stc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [STC_ADDR_W-1:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rd_data_o,
    input wire logic sleep_i,
    input wire logic cmp_reset_i,
    input wire logic [1:0] port_direction_i,
    input wire logic [1:0] port_out_i,
    input wire logic osc_input_pin_i,
    input wire logic osc_output_pin_i,
    output logic osc_input_pin_o,
    output logic osc_input_pin_oe_o,
    output logic osc_output_pin_o,
    output logic osc_output_pin_oe_o,
    output logic osc_run_o,
    output logic irq_o,
    output logic time_base_valid_o,
    output logic [15:0] count_o
);
    typedef struct packed {
        logic [5:0] ctrl;
        logic [15:0] count;
        logic ovf_flag;
        logic ovf_en;
        logic [1:0] insn_div;
        logic [2:0] pin_sync;
        logic pin_level;
        logic [STC_SYNC_STAGES-1:0] sync_pipe;
        logic [7:0] rd_data;
    } stc_state_type;

    stc_state_type state;
    stc_state_type next_state;
    stc_presc_if pif ();

    logic run;
    logic ext_src;
    logic sync_dis;
    logic osc_en;
    logic insn_en;
    logic src_pin;
    logic ext_rise;
    logic sync_mode;
    logic inc;
    logic wr_lo;
    logic wr_hi;
    logic wr_cnt;
    logic cmp_ok;
    logic wrap;
    logic [15:0] count_inc;

    assign run = state.ctrl[STC_BIT_RUN];
    assign ext_src = state.ctrl[STC_BIT_SRC];
    assign sync_dis = state.ctrl[STC_BIT_SYNC_DIS];
    assign osc_en = state.ctrl[STC_BIT_OSC_EN];
    assign insn_en = (state.insn_div == STC_OSC_PER_INSN);
    assign sync_mode = ext_src & ~sync_dis;

    // the crystal amplifier owns both pins while enabled; direction bits are ignored then
    assign osc_input_pin_oe_o = ~osc_en & ~port_direction_i[1];
    assign osc_output_pin_oe_o = ~osc_en & ~port_direction_i[0];
    assign osc_input_pin_o = port_out_i[1];
    assign osc_output_pin_o = port_out_i[0];
    assign osc_run_o = osc_en;

    assign src_pin = osc_en ? osc_input_pin_i : osc_output_pin_i;
    assign ext_rise = (state.pin_sync[1] == state.pin_sync[2]) & state.pin_sync[2]
        & ~state.pin_level;

    // core clock stops in sleep, so the internal source gives no events then
    assign pif.event_in = ext_src ? ext_rise : (insn_en & ~sleep_i);
    assign pif.ratio = state.ctrl[STC_BIT_PS_HI:STC_BIT_PS_LO];
    assign wr_lo = wr_i & (addr_i == STC_OFS_CNT_LO);
    assign wr_hi = wr_i & (addr_i == STC_OFS_CNT_HI);
    assign wr_cnt = wr_lo | wr_hi;
    assign pif.clear = wr_cnt;

    stc_prescaler #(
        .WIDTH(STC_PRESC_W)
    ) u_presc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pif(pif)
    );

    // unsync mode takes the tick straight away, so it is the only one alive in sleep
    always_comb begin
        if (!run) begin
            inc = 1'b0;
        end else if (!ext_src) begin
            inc = pif.tick;
        end else if (sync_dis) begin
            inc = pif.tick;
        end else begin
            // a tick still in the pipe when sleep starts is dropped, not counted
            inc = state.sync_pipe[STC_SYNC_STAGES-1] & ~sleep_i;
        end
    end

    // an async count would race the compare unit, so it is withheld from it
    assign time_base_valid_o = run & ~(ext_src & sync_dis);
    assign cmp_ok = cmp_reset_i & time_base_valid_o;
    assign count_inc = state.count + STC_COUNT_ONE;
    assign wrap = inc & (state.count == STC_COUNT_MAX) & ~wr_cnt & ~cmp_ok;
    assign irq_o = state.ovf_flag & state.ovf_en;
    assign count_o = state.count;
    assign rd_data_o = state.rd_data;

    always_comb begin
        next_state = state;
        next_state.insn_div = state.insn_div + 2'h1;
        // three stages; a change counts once the last two agree
        next_state.pin_sync = {state.pin_sync[1:0], src_pin};
        if (state.pin_sync[1] == state.pin_sync[2]) begin
            next_state.pin_level = state.pin_sync[2];
        end
        // the synchroniser is switched off in sleep, the prescaler is not
        if (sync_mode && !sleep_i) begin
            next_state.sync_pipe = {state.sync_pipe[STC_SYNC_STAGES-2:0], pif.tick};
        end else begin
            next_state.sync_pipe = '0;
        end
        if (wr_lo) begin
            next_state.count[7:0] = wr_data_i;
        end else if (wr_hi) begin
            next_state.count[15:8] = wr_data_i;
        end else if (cmp_ok) begin
            next_state.count = '0;
        end else if (inc) begin
            next_state.count = count_inc;
        end
        if (wr_i && addr_i == STC_OFS_CTRL) begin
            next_state.ctrl = wr_data_i[5:0] & STC_CTRL_MASK;
        end
        if (wr_i && addr_i == STC_OFS_IRQEN) begin
            next_state.ovf_en = wr_data_i[STC_BIT_OVF_EN];
        end
        // a wrap in the same cycle as a software clear keeps the flag set
        if (wrap) begin
            next_state.ovf_flag = 1'b1;
        end else if (wr_i && addr_i == STC_OFS_FLAG) begin
            next_state.ovf_flag = wr_data_i[STC_BIT_OVF_FLAG];
        end
        next_state.rd_data = 8'h00;
        if (rd_i) begin
            case (addr_i)
                STC_OFS_CNT_LO: next_state.rd_data = state.count[7:0];
                STC_OFS_CNT_HI: next_state.rd_data = state.count[15:8];
                STC_OFS_CTRL: next_state.rd_data = {2'b00, state.ctrl};
                STC_OFS_FLAG: next_state.rd_data = {7'h00, state.ovf_flag};
                STC_OFS_IRQEN: next_state.rd_data = {7'h00, state.ovf_en};
                default: next_state.rd_data = 8'h00;
            endcase
        end
    end

    // reset is power-on/brown-out: the count bytes keep their value, software must load them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= next_state;
            state.ctrl <= STC_CTRL_RESET;
            state.count <= state.count;
            state.ovf_flag <= 1'b0;
            state.ovf_en <= 1'b0;
            state.insn_div <= 2'h0;
            state.pin_sync <= 3'h0;
            state.pin_level <= 1'b0;
            state.sync_pipe <= '0;
            state.rd_data <= 8'h00;
        end else begin
            state <= next_state;
        end
    end

    sequence s_sync_tick;
        run && sync_mode && !sleep_i && pif.tick;
    endsequence

    sequence s_sync_hold;
        (run && sync_mode && !sleep_i)[*2];
    endsequence

    AST_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
        wrap |=> (state.count == 16'h0000) && state.ovf_flag)
        else $error("count did not wrap to zero with flag");
    AST_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
        (wrap && state.ovf_en && !(wr_i && addr_i == STC_OFS_IRQEN)) |=> irq_o)
        else $error("enabled overflow raised no interrupt");
    AST_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
        (!run && !wr_cnt) |=> $stable(state.count))
        else $error("stopped timer changed count");
    AST_SYNC_LAG: assert property (@(posedge clk_i) disable iff (rst_i)
        s_sync_tick ##1 s_sync_hold |-> inc)
        else $error("synchronised tick not counted two cycles later");
    AST_SLEEP_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (sync_mode && sleep_i && !wr_cnt && !cmp_reset_i) |=> $stable(state.count))
        else $error("synchronised counter moved in sleep");
    AST_WRITE_WINS: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_lo && cmp_reset_i) |=> (state.count[7:0] == $past(wr_data_i)))
        else $error("compare reset overrode count write");
    AST_PIN_IN: assert property (@(posedge clk_i) disable iff (rst_i)
        osc_en |-> !osc_input_pin_oe_o && !osc_output_pin_oe_o)
        else $error("oscillator pin driven while oscillator enabled");
    AST_CTRL_RD: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_i && addr_i == STC_OFS_CTRL) |=> (rd_data_o[7:6] == 2'b00))
        else $error("unimplemented control bits read nonzero");
    AST_CTRL_RST: assert property (@(posedge clk_i)
        rst_i |=> (state.ctrl == STC_CTRL_RESET))
        else $error("control not cleared by reset");
    AST_UNSYNC_BASE: assert property (@(posedge clk_i) disable iff (rst_i)
        (ext_src && sync_dis) |-> !time_base_valid_o)
        else $error("async count offered as compare time base");
endmodule // stc_timer
